// *** rtl/hpa_pkg.sv ***
// package: constants, types and register map of the hidden clock host
`default_nettype none
package hpa_pkg;
   // clock and pin timing of the memory bus
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned T_WP_NS = 100;
   localparam int unsigned T_ACC_NS = 150;
   localparam int unsigned T_WR_NS = 20;
   localparam int unsigned T_OD_NS = 70;
   localparam int unsigned WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned WR_CYC = (T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned OD_CYC = (T_OD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned REC_CYC = (WR_CYC > OD_CYC) ? WR_CYC : OD_CYC;
   localparam int unsigned SYNC_CYC = 3;
   localparam int unsigned CNT_W = 6;

   // memory bus and serial stream shape
   localparam int unsigned ADDR_W = 18;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned XFER_BITS = 64;
   localparam int unsigned BIT_W = 6;
   localparam logic [63:0] MATCH_PATTERN = 64'h5ca3_3ac5_5ca3_3ac5;

   // register map, one aligned word each
   localparam int unsigned APB_AW = 8;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_ADDR = 8'h08;
   localparam logic [7:0] OFS_WDATA = 8'h0c;
   localparam logic [7:0] OFS_RDATA = 8'h10;
   localparam logic [7:0] OFS_TX_LO = 8'h14;
   localparam logic [7:0] OFS_TX_HI = 8'h18;
   localparam logic [7:0] OFS_RX_LO = 8'h1c;
   localparam logic [7:0] OFS_RX_HI = 8'h20;
   localparam int unsigned CTRL_START_BIT = 0;
   localparam int unsigned CTRL_CMD_LSB = 1;
   localparam int unsigned STAT_BUSY_BIT = 0;
   localparam int unsigned STAT_DONE_BIT = 1;
   localparam logic [17:0] ADDR_RST = 18'h00000;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [63:0] BITS_RST = 64'h0;

   typedef enum logic [1:0] {
      CMD_CLK_READ, CMD_CLK_WRITE, CMD_MEM_READ, CMD_MEM_WRITE
   } hpa_cmd_t;

   typedef struct packed {
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } hpa_cyc_req_t;

   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq_out;
      logic dq_oe_n;
   } hpa_pins_t;

   localparam hpa_pins_t PINS_IDLE = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
      addr: ADDR_RST, dq_out: BYTE_RST, dq_oe_n: 1'b1};
endpackage
`default_nettype wire

// *** rtl/hpa_pin_cycle.sv ***
// one asynchronous memory bus cycle, read or write, on the device pins
`timescale 1ns/1ps
`default_nettype none
module hpa_pin_cycle (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic i_start,
   input wire hpa_pkg::hpa_cyc_req_t i_req,
   input wire logic [hpa_pkg::DATA_W-1:0] i_dq_in,
   output logic o_busy,
   output logic o_done,
   output logic [hpa_pkg::DATA_W-1:0] o_rdata,
   output hpa_pkg::hpa_pins_t o_pins
);
   import hpa_pkg::*;

   typedef enum logic [1:0] {CY_IDLE, CY_SETUP, CY_STROBE, CY_RECOVER} hpa_cy_t;

   hpa_cy_t st_q, st_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   hpa_cyc_req_t req_q, req_d;
   hpa_pins_t pins_q, pins_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   logic [DATA_W-1:0] s1_q, s2_q, s3_q;
   logic done;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      req_d = req_q;
      pins_d = pins_q;
      rdata_d = rdata_q;
      done = 1'b0;
      unique case (st_q)
         CY_IDLE: begin
            if (i_start) begin
               req_d = i_req;
               pins_d.addr = i_req.addr;
               pins_d.dq_out = i_req.wdata;
               pins_d.dq_oe_n = ~i_req.write;
               st_d = CY_SETUP;
            end
         end
         CY_SETUP: begin
            // address settled one cycle before the strobe
            pins_d.ce_n = 1'b0;
            pins_d.we_n = ~req_q.write;
            pins_d.oe_n = req_q.write;
            cnt_d = req_q.write ? CNT_W'(WP_CYC - 1)
                                : CNT_W'(ACC_CYC + SYNC_CYC - 1);
            st_d = CY_STROBE;
         end
         CY_STROBE: begin
            if (cnt_q != '0) begin
               cnt_d = cnt_q - CNT_W'(1);
            end else if (req_q.write || (s2_q == s3_q)) begin
               if (!req_q.write) begin
                  rdata_d = s3_q;
               end
               pins_d.ce_n = 1'b1;
               pins_d.we_n = 1'b1;
               pins_d.oe_n = 1'b1;
               cnt_d = CNT_W'(REC_CYC - 1);
               st_d = CY_RECOVER;
            end
         end
         CY_RECOVER: begin
            // address and data held past the strobe's rising edge
            if (cnt_q != '0) begin
               cnt_d = cnt_q - CNT_W'(1);
            end else begin
               pins_d.dq_oe_n = 1'b1;
               done = 1'b1;
               st_d = CY_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_q <= CY_IDLE;
         cnt_q <= '0;
         req_q <= '0;
         pins_q <= PINS_IDLE;
         rdata_q <= BYTE_RST;
         s1_q <= BYTE_RST;
         s2_q <= BYTE_RST;
         s3_q <= BYTE_RST;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         req_q <= req_d;
         pins_q <= pins_d;
         rdata_q <= rdata_d;
         s1_q <= i_dq_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   assign o_busy = (st_q != CY_IDLE);
   assign o_done = done;
   assign o_rdata = rdata_q;
   assign o_pins = pins_q;

   ////////////////////////////////////////////////////////////////////////////
   sequence we_low_run;
      (!pins_q.we_n)[*8];
   endsequence

   addr_stable_a: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (!pins_q.we_n || st_q == CY_RECOVER) && (st_q != CY_IDLE)
      && $past(st_q != CY_IDLE) |-> $stable(pins_q.addr))
      else $error("address moved during a write cycle");

   oe_quiet_a: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      !pins_q.we_n |-> pins_q.oe_n)
      else $error("output enable active during a write");

   no_contend_a: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      !pins_q.dq_oe_n |-> pins_q.oe_n && req_q.write)
      else $error("data bus driven while device outputs may be on");

   strobe_width_a: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      $fell(pins_q.we_n) |-> we_low_run)
      else $error("write strobe too short");
endmodule
`default_nettype wire

// *** rtl/hpa_ctrl.sv ***
// host controller: unlocks and transfers the hidden clock over a memory bus
`timescale 1ns/1ps
`default_nettype none
module hpa_ctrl (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [hpa_pkg::APB_AW-1:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic [hpa_pkg::DATA_W-1:0] i_dq_in,
   output hpa_pkg::hpa_pins_t o_pins
);
   import hpa_pkg::*;

   typedef enum logic [2:0] {OP_IDLE, OP_ARM, OP_PATTERN, OP_XFER, OP_MEM}
      hpa_op_t;

   function automatic logic reg_hit(input logic [APB_AW-1:0] a);
      reg_hit = (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_ADDR)
         || (a == OFS_WDATA) || (a == OFS_RDATA) || (a == OFS_TX_LO)
         || (a == OFS_TX_HI) || (a == OFS_RX_LO) || (a == OFS_RX_HI);
   endfunction

   // software registers
   hpa_cmd_t cmd_q, cmd_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [DATA_W-1:0] wdata_q, wdata_d;
   logic [63:0] tx_q, tx_d;
   logic [31:0] prdata_q, prdata_d;
   logic pslverr_q, pslverr_d;
   // operation state
   hpa_op_t st_q, st_d;
   logic [BIT_W-1:0] bit_q, bit_d;
   logic [63:0] rx_q, rx_d;
   logic [DATA_W-1:0] mem_rd_q, mem_rd_d;
   logic done_q, done_d;
   // glue
   logic wr_en, setup, busy, sw_start, done_clr, op_finish;
   hpa_cmd_t start_cmd;
   hpa_cyc_req_t cyc_req;
   logic cyc_start, cyc_busy, cyc_done;
   logic [DATA_W-1:0] cyc_rdata;
   logic last_rd_q;

   ////////////////////////////////////////////////////////////////////////////
   // apb slave: data and error registered in setup, answered with no wait
   assign setup = i_psel && !i_penable;
   assign wr_en = i_psel && i_penable && i_pwrite;
   assign busy = (st_q != OP_IDLE);
   assign start_cmd = hpa_cmd_t'(i_pwdata[CTRL_CMD_LSB +: 2]);
   assign sw_start = wr_en && !busy && (i_paddr == OFS_CTRL)
      && i_pwdata[CTRL_START_BIT];
   assign done_clr = wr_en && (i_paddr == OFS_STATUS)
      && i_pwdata[STAT_DONE_BIT];

   always_comb begin
      cmd_d = cmd_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      tx_d = tx_q;
      prdata_d = prdata_q;
      pslverr_d = pslverr_q;
      if (setup) begin
         pslverr_d = ~reg_hit(i_paddr);
         prdata_d = 32'h0000_0000;
         if (!i_pwrite) begin
            unique case (i_paddr)
               OFS_CTRL: prdata_d = {29'h0, cmd_q, 1'b0};
               OFS_STATUS: prdata_d = {30'h0, done_q, busy};
               OFS_ADDR: prdata_d = {14'h0, addr_q};
               OFS_WDATA: prdata_d = {24'h0, wdata_q};
               OFS_RDATA: prdata_d = {24'h0, mem_rd_q};
               OFS_TX_LO: prdata_d = tx_q[31:0];
               OFS_TX_HI: prdata_d = tx_q[63:32];
               OFS_RX_LO: prdata_d = rx_q[31:0];
               OFS_RX_HI: prdata_d = rx_q[63:32];
               default: prdata_d = 32'h0000_0000;
            endcase
         end
      end
      // set-up registers are frozen while an operation runs
      if (wr_en && !busy) begin
         unique case (i_paddr)
            OFS_CTRL: cmd_d = start_cmd;
            OFS_ADDR: addr_d = i_pwdata[ADDR_W-1:0];
            OFS_WDATA: wdata_d = i_pwdata[DATA_W-1:0];
            OFS_TX_LO: tx_d[31:0] = i_pwdata;
            OFS_TX_HI: tx_d[63:32] = i_pwdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cmd_q <= CMD_CLK_READ;
         addr_q <= ADDR_RST;
         wdata_q <= BYTE_RST;
         tx_q <= BITS_RST;
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else begin
         cmd_q <= cmd_d;
         addr_q <= addr_d;
         wdata_q <= wdata_d;
         tx_q <= tx_d;
         prdata_q <= prdata_d;
         pslverr_q <= pslverr_d;
      end
   end

   assign o_prdata = prdata_q;
   assign o_pready = 1'b1;
   assign o_pslverr = pslverr_q;

   ////////////////////////////////////////////////////////////////////////////
   // operation sequencer: arm read, 64 pattern writes, 64 clock bit cycles
   assign cyc_start = busy && !cyc_busy;

   always_comb begin
      cyc_req.write = 1'b0;
      cyc_req.addr = addr_q;
      cyc_req.wdata = BYTE_RST;
      unique case (st_q)
         OP_PATTERN: begin
            cyc_req.write = 1'b1;
            cyc_req.wdata = {7'h00, MATCH_PATTERN[bit_q]};
         end
         OP_XFER: begin
            cyc_req.write = (cmd_q == CMD_CLK_WRITE);
            cyc_req.wdata = {7'h00, tx_q[bit_q]};
         end
         OP_MEM: begin
            cyc_req.write = (cmd_q == CMD_MEM_WRITE);
            cyc_req.wdata = wdata_q;
         end
         default: ;
      endcase
   end

   always_comb begin
      st_d = st_q;
      bit_d = bit_q;
      rx_d = rx_q;
      mem_rd_d = mem_rd_q;
      op_finish = 1'b0;
      unique case (st_q)
         OP_IDLE: begin
            if (sw_start) begin
               st_d = (start_cmd == CMD_MEM_READ || start_cmd == CMD_MEM_WRITE)
                  ? OP_MEM : OP_ARM;
               bit_d = '0;
            end
         end
         OP_ARM: begin
            if (cyc_done) begin
               st_d = OP_PATTERN;
            end
         end
         OP_PATTERN: begin
            if (cyc_done) begin
               bit_d = bit_q + BIT_W'(1);
               if (bit_q == BIT_W'(XFER_BITS - 1)) begin
                  st_d = OP_XFER;
               end
            end
         end
         OP_XFER: begin
            if (cyc_done) begin
               if (cmd_q == CMD_CLK_READ) begin
                  rx_d[bit_q] = cyc_rdata[0];
               end
               bit_d = bit_q + BIT_W'(1);
               if (bit_q == BIT_W'(XFER_BITS - 1)) begin
                  st_d = OP_IDLE;
                  op_finish = 1'b1;
               end
            end
         end
         OP_MEM: begin
            if (cyc_done) begin
               if (cmd_q == CMD_MEM_READ) begin
                  mem_rd_d = cyc_rdata;
               end
               st_d = OP_IDLE;
               op_finish = 1'b1;
            end
         end
         default: st_d = OP_IDLE;
      endcase
      // a finish in the clearing cycle still leaves the flag set
      done_d = (done_q && !done_clr) || op_finish;
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_q <= OP_IDLE;
         bit_q <= '0;
         rx_q <= BITS_RST;
         mem_rd_q <= BYTE_RST;
         done_q <= 1'b0;
      end else begin
         st_q <= st_d;
         bit_q <= bit_d;
         rx_q <= rx_d;
         mem_rd_q <= mem_rd_d;
         done_q <= done_d;
      end
   end

   hpa_pin_cycle u_pin_cycle (
      .i_ref_clk(i_ref_clk),
      .i_reset_n(i_reset_n),
      .i_start(cyc_start),
      .i_req(cyc_req),
      .i_dq_in(i_dq_in),
      .o_busy(cyc_busy),
      .o_done(cyc_done),
      .o_rdata(cyc_rdata),
      .o_pins(o_pins)
   );

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         last_rd_q <= 1'b0;
      end else if (cyc_start) begin
         last_rd_q <= ~cyc_req.write;
      end
   end

   sequence xfer_entry;
      $rose(st_q == OP_XFER);
   endsequence

   sequence xfer_exit;
      $fell(st_q == OP_XFER);
   endsequence

   arm_read_first_a: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (st_q == OP_PATTERN && cyc_start && bit_q == '0) |-> last_rd_q)
      else $error("pattern started without a preceding read");

   scratch_only_a: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (st_q == OP_PATTERN && !o_pins.ce_n) |-> o_pins.addr == addr_q)
      else $error("pattern write left the scratch address");

   pattern_bit_a: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (st_q == OP_PATTERN && !o_pins.we_n) |->
      o_pins.dq_out == {7'h00, MATCH_PATTERN[bit_q]})
      else $error("wrong pattern bit sent");

   xfer_start_a: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      xfer_entry |-> bit_q == '0 && $past(bit_q) == BIT_W'(XFER_BITS - 1))
      else $error("transfer did not start at bit 0");

   bit_step_a: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      (st_q == OP_XFER && cyc_done) |=> bit_q == $past(bit_q) + BIT_W'(1))
      else $error("transfer bit order broken");

   whole_group_a: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      xfer_exit |-> $past(bit_q) == BIT_W'(XFER_BITS - 1) && done_q)
      else $error("transfer ended before bit 7 of register 7");
endmodule
`default_nettype wire

// *** test/hpa_dev_model.sv ***
// behavioural memory device with a hidden serial clock behind its bus
`timescale 1ns/1ps
`default_nettype none
module hpa_dev_model #(
   parameter int DLY_NS = 120
) (
   input wire logic i_ce_n,
   input wire logic i_oe_n,
   input wire logic i_we_n,
   input wire logic [hpa_pkg::ADDR_W-1:0] i_addr,
   input wire logic [hpa_pkg::DATA_W-1:0] i_dq,
   output logic [hpa_pkg::DATA_W-1:0] o_dq,
   output logic o_dq_en
);
   import hpa_pkg::*;
   localparam logic [63:0] PAT = {2{8'h5c, 8'ha3, 8'h3a, 8'hc5}};
   logic [7:0] mem [logic [17:0]];
   // day register ships with reset-ignore and oscillator-stop set
   logic [63:0] regs = 64'h9902_2831_2359_5947;
   logic [63:0] snap = '0;
   logic [7:0] val_v;
   logic armed = 1'b0;
   logic win = 1'b0;
   logic wr_act = 1'b0;
   logic rd_act = 1'b0;
   int ptr = 0;
   int cnt = 0;
   ////////////////////////////////////////////////////////////////////
   task automatic step();
      cnt++;
      if (cnt == 64) win = 1'b0;
   endtask
   // data turns valid late, drive stops at once
   assign o_dq_en = !i_ce_n && !i_oe_n && i_we_n;
   assign #(DLY_NS) o_dq = val_v;
   always @(i_ce_n, i_oe_n, i_we_n, i_addr, win, cnt, snap) begin
      if (win) val_v = {7'h00, snap[cnt]};
      else if (mem.exists(i_addr)) val_v = mem[i_addr];
      else val_v = 8'hff;
   end
   // chip and write enable may fall in either order within one time step,
   // so a read is only acted on once it ends without a write enable
   always @(negedge i_ce_n or negedge i_we_n) begin
      if (!i_ce_n && !i_we_n) begin
         wr_act = 1'b1;
         rd_act = 1'b0;
      end else if (!i_ce_n && i_we_n) begin
         rd_act = 1'b1;
         if (win && cnt == 0) snap = regs;
      end
   end
   always @(posedge i_ce_n or posedge i_we_n) begin
      if (wr_act) begin
         wr_act = 1'b0;
         if (win) begin
            regs[cnt] = i_dq[0];
            step();
         end else begin
            mem[i_addr] = i_dq;
            if (armed && i_dq[0] === PAT[ptr]) ptr++;
            else armed = 1'b0;
            if (ptr == 64) begin
               win = 1'b1;
               cnt = 0;
               armed = 1'b0;
               ptr = 0;
            end
         end
      end else if (rd_act && i_ce_n) begin
         rd_act = 1'b0;
         if (win) step();
         else begin
            armed = 1'b1;
            ptr = 0;
         end
      end
   end
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// top testbench: drives the controller over apb against a device model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import hpa_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   hpa_pins_t pins;
   logic [7:0] dev_dq;
   logic dev_en;
   logic [7:0] bus;
   logic [7:0] last_bus = 8'h00;
   logic [17:0] wr_addr = '0;
   logic in_wr = 1'b0;
   logic [31:0] v;
   logic e;
   int miscompares = 0;
   int n_compared = 0;
   ////////////////////////////////////////////////////////////////////
   initial begin
      forever #2 clk = ~clk;
   end
   // released bus shows a value that changes every cycle
   assign bus = (pins.dq_oe_n === 1'b0) ? pins.dq_out
      : ((dev_en === 1'b1) ? dev_dq : ~last_bus);
   always @(posedge clk) last_bus <= bus;
   hpa_ctrl dut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_dq_in(bus), .o_pins(pins));
   hpa_dev_model #(.DLY_NS(120)) dev (.i_ce_n(pins.ce_n),
      .i_oe_n(pins.oe_n), .i_we_n(pins.we_n), .i_addr(pins.addr),
      .i_dq(bus), .o_dq(dev_dq), .o_dq_en(dev_en));
   ////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      v = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input string nm, input logic [7:0] a,
      input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(nm, v, exp);
   endtask
   task automatic go(input logic [1:0] c);
      xfer(1'b1, OFS_CTRL, {29'h0, c, 1'b1});
   endtask
   task automatic wait_done();
      int n = 0;
      do begin
         xfer(1'b0, OFS_STATUS, 32'h0);
         n++;
      end while (v[STAT_DONE_BIT] !== 1'b1 && n < 6000);
      chk("done", {31'h0, v[STAT_DONE_BIT]}, 32'h1);
      xfer(1'b1, OFS_STATUS, 32'h2);
      rdchk("status_clr", OFS_STATUS, 32'h0);
   endtask
   ////////////////////////////////////////////////////////////////////
   // pin watch: write cycles keep output enable off and address still
   always @(negedge clk) begin
      if (rst_n && !pins.we_n) begin
         chk("oe_in_write", {31'h0, pins.oe_n}, 32'h1);
         if (in_wr) chk("addr_hold", {14'h0, pins.addr}, {14'h0, wr_addr});
         wr_addr = pins.addr;
         in_wr = 1'b1;
      end else in_wr = 1'b0;
      if (!pins.dq_oe_n && dev_en) chk("bus_clash", 32'h1, 32'h0);
   end
   initial begin
      #300000;
      miscompares++;
      complete_run();
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rdchk("status_rst", OFS_STATUS, 32'h0);
      rdchk("addr_rst", OFS_ADDR, 32'h0);
      xfer(1'b1, 8'h40, 32'h1);
      chk("unmapped_err", {31'h0, e}, 32'h1);
      rdchk("unmapped_rd", 8'h40, 32'h0);
      xfer(1'b1, OFS_ADDR, 32'h123);
      rdchk("addr_rw", OFS_ADDR, 32'h123);
      $display("test registers done");
      xfer(1'b1, OFS_WDATA, 32'ha5);
      go(2'd3);
      wait_done();
      go(2'd2);
      wait_done();
      rdchk("mem_rd", OFS_RDATA, 32'ha5);
      $display("test memory done");
      go(2'd0);
      rdchk("busy", OFS_STATUS, 32'h1);
      xfer(1'b1, OFS_ADDR, 32'h3ffff);
      wait_done();
      rdchk("addr_kept", OFS_ADDR, 32'h123);
      rdchk("rx_lo", OFS_RX_LO, 32'h2359_5947);
      rdchk("rx_hi", OFS_RX_HI, 32'h9902_2831);
      go(2'd2);
      wait_done();
      rdchk("scratch", OFS_RDATA, 32'h0);
      $display("test clock read done");
      xfer(1'b1, OFS_TX_LO, 32'ha530_1500);
      xfer(1'b1, OFS_TX_HI, 32'h9912_3106);
      go(2'd1);
      wait_done();
      rdchk("ctrl_rd", OFS_CTRL, 32'h2);
      rdchk("tx_hi_rd", OFS_TX_HI, 32'h9912_3106);
      go(2'd2);
      wait_done();
      rdchk("scratch_kept", OFS_RDATA, 32'h0);
      go(2'd0);
      wait_done();
      rdchk("rx_lo2", OFS_RX_LO, 32'ha530_1500);
      rdchk("rx_hi2", OFS_RX_HI, 32'h9912_3106);
      $display("test clock write done");
      complete_run();
   end
endmodule
`default_nettype wire
